// [hdl/hsic_top.sv]
// Hot-swap insertion control: reset, LED, option capture, insertion and extraction flags
//
// Contract
// - Light LED when unhealthy or LED request set
// - Ejector low is open, high closed
// - LED off means pin released, not driven
// - Internal reset is unhealthy OR PCI reset
// - Unhealthy: stay reset, float all but LED
// - Healthy with PCI reset: drive local reset low
// - Capture options on healthy, PCI reset, local reset
// - Load EEPROM when leaving reset, if enabled
// - After load: insertion flag, ENUM, accept config
// - Access hold: withhold ENUM, retry config
// - Clearing hold completes insertion and enumeration
// - Host write clears insertion flag, ENUM released
// - Ejector falling edge sets extraction flag, ENUM
// - Host write clears extraction flag, ENUM released
//
// The strobed register port and the address map were left to the implementer.
`timescale 1ns/10ps
`default_nettype none
module hsic_top
	import hsic_pkg::*;
#(
	parameter int OPT_W = 4 // Number of power-up option pins
)
(
	input  wire logic             sys_clk_i,
	input  wire logic             rst_n_i,
	// Register port
	input  wire logic [7:0]       reg_addr_i,
	input  wire logic [31:0]      reg_wdata_i,
	input  wire logic             reg_wr_i,
	input  wire logic             reg_rd_i,
	output logic      [31:0]      reg_rdata_o,
	// Slot pins
	input  wire logic             backend_healthy_n_i,
	input  wire logic             ejector_switch_in_i,
	input  wire logic             pci_rst_n_i,
	input  wire logic             local_reset_in_n_i,
	input  wire logic [OPT_W-1:0] power_opt_i,
	output logic                  slot_led_pin_o,
	output logic                  slot_led_pin_oe_n_o,
	output logic                  enum_n_o,
	output logic                  enum_n_oe_n_o,
	output logic                  local_reset_out_n_o,
	output logic                  local_reset_out_n_oe_n_o,
	output logic                  outputs_float_o,
	// EEPROM loader handshake
	output logic                  eeprom_start_o,
	input  wire logic             eeprom_done_i,
	// Configuration cycle gating
	output logic                  config_accept_o,
	output logic                  config_retry_o,
	output logic                  irq_o
);
	// Elaboration check on option width
	if (OPT_W < HSIC_OPT_MIN_W)
	begin : g_bad_opt
		$error("hsic_top: OPT_W too small");
	end

	logic                rst_meta_reg;  // Reset release stage one
	logic                rst_n_reg;     // Released reset used everywhere
	logic                healthy_n_s;   // Filtered healthy, low = back-end up
	logic                eject_s;       // Filtered ejector, high = latch closed
	logic                pci_rst_n_s;   // Filtered PCI reset
	logic                lrst_in_n_s;   // Filtered local reset input
	logic [OPT_W-1:0]    opt_s;         // Filtered option pins
	logic                healthy_n_d_reg; // Previous values for edge detect
	logic                eject_d_reg;
	logic                pci_rst_n_d_reg;
	logic                lrst_in_n_d_reg;
	logic                int_reset;     // Internal reset
	logic                capture;       // Option capture event
	logic                eject_fall;    // Latch has just opened
	logic [OPT_W-1:0]    opt_reg;       // Captured power-up options
	hsic_state_t         state_reg;
	hsic_state_t         state_next;
	logic                ins_reg;
	logic                ext_reg;
	logic                loo_reg;
	logic                eim_reg;
	logic                hold_reg;      // Access hold control bit
	logic                ins_set;
	logic                ext_set;
	logic                hs_wr;
	logic                misc_wr;
	logic                mask_wr;
	logic [HSIC_EV_W-1:0] irq_stat_reg;
	logic [HSIC_EV_W-1:0] irq_mask_reg;
	logic [HSIC_EV_W-1:0] irq_ev;
	logic                irq_rd;
	logic [31:0]         rdata_next;

	// Release the asynchronous reset through two flops
	always_ff @(posedge sys_clk_i or negedge rst_n_i)
	begin
		if (!rst_n_i)
		begin
			rst_meta_reg <= 1'b0;
			rst_n_reg    <= 1'b0;
		end
		else
		begin
			rst_meta_reg <= 1'b1;
			rst_n_reg    <= rst_meta_reg;
		end
	end

	// Pin synchronisers; PCI reset comes up asserted, local reset input released, back-end unhealthy
	hsic_sync #(.WIDTH(4), .INIT(4'b1001)) u_sync_ctl
	(
		.sys_clk_i (sys_clk_i),
		.rst_n_i   (rst_n_reg),
		.pin_i     ({backend_healthy_n_i, ejector_switch_in_i,
		             pci_rst_n_i, local_reset_in_n_i}),
		.level_o   ({healthy_n_s, eject_s, pci_rst_n_s, lrst_in_n_s})
	);

	hsic_sync #(.WIDTH(OPT_W)) u_sync_opt
	(
		.sys_clk_i (sys_clk_i),
		.rst_n_i   (rst_n_reg),
		.pin_i     (power_opt_i),
		.level_o   (opt_s)
	);

	// Previous filtered levels for edge detection
	always_ff @(posedge sys_clk_i or negedge rst_n_reg)
	begin
		if (!rst_n_reg)
		begin
			healthy_n_d_reg <= 1'b1;
			eject_d_reg     <= 1'b0;
			pci_rst_n_d_reg <= 1'b0;
			lrst_in_n_d_reg <= 1'b1; // Idle high like its synchroniser, so no false capture
		end
		else
		begin
			healthy_n_d_reg <= healthy_n_s;
			eject_d_reg     <= eject_s;
			pci_rst_n_d_reg <= pci_rst_n_s;
			lrst_in_n_d_reg <= lrst_in_n_s;
		end
	end

	assign int_reset  = healthy_n_s | ~pci_rst_n_s;
	assign capture    = (healthy_n_d_reg & ~healthy_n_s) |
	                    (~pci_rst_n_d_reg & pci_rst_n_s) |
	                    (~lrst_in_n_d_reg & lrst_in_n_s);
	// low means open, so a fall is opening
	assign eject_fall = eject_d_reg & ~eject_s;

	// Power-up option capture; kept through internal reset so reset exit sees it
	always_ff @(posedge sys_clk_i or negedge rst_n_reg)
	begin
		if (!rst_n_reg)
		begin
			opt_reg <= '0;
		end
		else if (capture)
		begin
			opt_reg <= opt_s;
		end
	end

	// Register port decode
	assign hs_wr   = reg_wr_i && (reg_addr_i == HSIC_ADDR_HS_STAT);
	assign misc_wr = reg_wr_i && (reg_addr_i == HSIC_ADDR_MISC_TWO);
	assign mask_wr = reg_wr_i && (reg_addr_i == HSIC_ADDR_IRQ_MASK);
	assign irq_rd  = reg_rd_i && (reg_addr_i == HSIC_ADDR_IRQ_STAT);

	// Sequencer next state
	always_comb
	begin
		state_next = state_reg;
		case (state_reg)
			HSIC_ST_RESET:
			begin
				// leave reset once healthy and PCI reset released
				if (!int_reset)
				begin
					state_next = HSIC_ST_START;
				end
			end
			HSIC_ST_START:
			begin
				if (opt_reg[HSIC_OPT_EEPROM])
				begin
					state_next = HSIC_ST_LOAD;
				end
				else if (hold_reg)
				begin
					state_next = HSIC_ST_HOLD;
				end
				else
				begin
					state_next = HSIC_ST_READY;
				end
			end
			HSIC_ST_LOAD:
			begin
				// finish load, then hold or go ready
				if (eeprom_done_i)
				begin
					state_next = hold_reg ? HSIC_ST_HOLD : HSIC_ST_READY;
				end
			end
			HSIC_ST_HOLD:
			begin
				if (!hold_reg)
				begin
					state_next = HSIC_ST_READY;
				end
			end
			HSIC_ST_READY:
			begin
				state_next = HSIC_ST_READY;
			end
			default:
			begin
				state_next = HSIC_ST_RESET;
			end
		endcase
	end

	// Sequencer state; internal reset overrides every state
	always_ff @(posedge sys_clk_i or negedge rst_n_reg)
	begin
		if (!rst_n_reg)
		begin
			state_reg <= HSIC_ST_RESET;
		end
		else if (int_reset)
		begin
			state_reg <= HSIC_ST_RESET;
		end
		else
		begin
			state_reg <= state_next;
		end
	end

	// Insertion set on entering ready; extraction on latch opening when ready
	assign ins_set = (state_reg != HSIC_ST_READY) && (state_next == HSIC_ST_READY) && !int_reset;
	assign ext_set = (state_reg == HSIC_ST_READY) && eject_fall;

	// Hot-swap flags; a set in the clearing cycle wins
	always_ff @(posedge sys_clk_i or negedge rst_n_reg)
	begin
		if (!rst_n_reg)
		begin
			ins_reg <= HSIC_HS_RESET[HSIC_BIT_INS];
			ext_reg <= HSIC_HS_RESET[HSIC_BIT_EXT];
			loo_reg <= HSIC_HS_RESET[HSIC_BIT_LOO];
			eim_reg <= HSIC_HS_RESET[HSIC_BIT_EIM];
		end
		else if (int_reset)
		begin
			ins_reg <= HSIC_HS_RESET[HSIC_BIT_INS];
			ext_reg <= HSIC_HS_RESET[HSIC_BIT_EXT];
			loo_reg <= HSIC_HS_RESET[HSIC_BIT_LOO];
			eim_reg <= HSIC_HS_RESET[HSIC_BIT_EIM];
		end
		else
		begin
			if (ins_set)
			begin
				ins_reg <= 1'b1;
			end
			else if (hs_wr && reg_wdata_i[HSIC_BIT_INS])
			begin
				ins_reg <= 1'b0;
			end
			if (ext_set)
			begin
				ext_reg <= 1'b1;
			end
			else if (hs_wr && reg_wdata_i[HSIC_BIT_EXT])
			begin
				ext_reg <= 1'b0;
			end
			// LED request and ENUM mask are plain read/write
			if (hs_wr)
			begin
				loo_reg <= reg_wdata_i[HSIC_BIT_LOO];
				eim_reg <= reg_wdata_i[HSIC_BIT_EIM];
			end
		end
	end

	// Access hold bit: loaded from its option pin, cleared by the local host
	always_ff @(posedge sys_clk_i or negedge rst_n_reg)
	begin
		if (!rst_n_reg)
		begin
			hold_reg <= 1'b0;
		end
		else if (capture)
		begin
			hold_reg <= opt_s[HSIC_OPT_HOLD];
		end
		else if (misc_wr)
		begin
			hold_reg <= reg_wdata_i[HSIC_BIT_HOLD];
		end
	end

	// Pin drivers, all registered
	always_ff @(posedge sys_clk_i or negedge rst_n_reg)
	begin
		if (!rst_n_reg)
		begin
			slot_led_pin_o           <= 1'b0;
			slot_led_pin_oe_n_o      <= 1'b0;
			enum_n_o                 <= 1'b0;
			enum_n_oe_n_o            <= 1'b1;
			local_reset_out_n_o      <= 1'b0;
			local_reset_out_n_oe_n_o <= 1'b1;
			outputs_float_o          <= 1'b1;
		end
		else
		begin
			slot_led_pin_o      <= 1'b0;
			slot_led_pin_oe_n_o <= ~(healthy_n_s | loo_reg);
			enum_n_o            <= 1'b0;
			enum_n_oe_n_o       <= ~((ins_reg | ext_reg) && !eim_reg &&
			                         (state_reg == HSIC_ST_READY) && !int_reset);
			// local reset follows PCI reset while healthy
			local_reset_out_n_o      <= pci_rst_n_s;
			local_reset_out_n_oe_n_o <= healthy_n_s;
			outputs_float_o          <= healthy_n_s;
		end
	end

	// EEPROM start pulse and configuration gating
	always_ff @(posedge sys_clk_i or negedge rst_n_reg)
	begin
		if (!rst_n_reg)
		begin
			eeprom_start_o  <= 1'b0;
			config_accept_o <= 1'b0;
			config_retry_o  <= 1'b0;
		end
		else
		begin
			eeprom_start_o  <= (state_next == HSIC_ST_LOAD) &&
			                   (state_reg != HSIC_ST_LOAD) && !int_reset;
			config_accept_o <= (state_next == HSIC_ST_READY) && !int_reset;
			config_retry_o  <= !int_reset && ((state_next == HSIC_ST_LOAD) ||
			                   (state_next == HSIC_ST_HOLD) ||
			                   (state_next == HSIC_ST_START));
		end
	end

	// Event sources for the interrupt status
	assign irq_ev = {eject_s != eject_d_reg, ext_set, ins_set};

	// Sticky status, cleared by reading, set wins
	always_ff @(posedge sys_clk_i or negedge rst_n_reg)
	begin
		if (!rst_n_reg)
		begin
			irq_stat_reg <= '0;
		end
		else
		begin
			irq_stat_reg <= (irq_rd ? '0 : irq_stat_reg) | irq_ev;
		end
	end

	// Mask register, one enables an event
	always_ff @(posedge sys_clk_i or negedge rst_n_reg)
	begin
		if (!rst_n_reg)
		begin
			irq_mask_reg <= HSIC_MASK_RESET;
		end
		else if (mask_wr)
		begin
			irq_mask_reg <= reg_wdata_i[HSIC_EV_W-1:0];
		end
	end

	// Interrupt level from a flop
	always_ff @(posedge sys_clk_i or negedge rst_n_reg)
	begin
		if (!rst_n_reg)
		begin
			irq_o <= 1'b0;
		end
		else
		begin
			irq_o <= |(((irq_rd ? '0 : irq_stat_reg) | irq_ev) & irq_mask_reg);
		end
	end

	// Read mux; unmapped addresses read zero
	always_comb
	begin
		rdata_next = 32'h0000_0000;
		case (reg_addr_i)
			HSIC_ADDR_HS_STAT:
			begin
				rdata_next[HSIC_BIT_INS] = ins_reg;
				rdata_next[HSIC_BIT_EXT] = ext_reg;
				rdata_next[HSIC_BIT_LOO] = loo_reg;
				rdata_next[HSIC_BIT_EIM] = eim_reg;
			end
			HSIC_ADDR_MISC_TWO:
			begin
				rdata_next[HSIC_BIT_HOLD] = hold_reg;
			end
			HSIC_ADDR_IRQ_STAT:
			begin
				rdata_next[HSIC_EV_W-1:0] = irq_stat_reg;
			end
			HSIC_ADDR_IRQ_MASK:
			begin
				rdata_next[HSIC_EV_W-1:0] = irq_mask_reg;
			end
			HSIC_ADDR_BLK_STAT:
			begin
				// State, latch, healthy, PCI reset, then captured options from bit 8
				rdata_next[2:0]         = state_reg;
				rdata_next[3]           = eject_s;
				rdata_next[4]           = healthy_n_s;
				rdata_next[5]           = pci_rst_n_s;
				rdata_next[8+:OPT_W]    = opt_reg;
			end
			default:
			begin
				rdata_next = 32'h0000_0000;
			end
		endcase
	end

	// Read data stands only in the cycle after the strobe
	always_ff @(posedge sys_clk_i or negedge rst_n_reg)
	begin
		if (!rst_n_reg)
		begin
			reg_rdata_o <= 32'h0000_0000;
		end
		else
		begin
			reg_rdata_o <= reg_rd_i ? rdata_next : 32'h0000_0000;
		end
	end
endmodule
`default_nettype wire

// [pkg/hsic_pkg.sv]
// Constants, register map and state codes of the hot-swap insertion control
package hsic_pkg;
	// Register word addresses on the plain register port
	localparam logic [7:0] HSIC_ADDR_HS_STAT   = 8'h00; // Hot-swap control and status
	localparam logic [7:0] HSIC_ADDR_MISC_TWO  = 8'h04; // Miscellaneous control two
	localparam logic [7:0] HSIC_ADDR_IRQ_STAT  = 8'h08; // Sticky event status
	localparam logic [7:0] HSIC_ADDR_IRQ_MASK  = 8'h0C; // Event mask
	localparam logic [7:0] HSIC_ADDR_BLK_STAT  = 8'h10; // Live block state
	// Field positions in the hot-swap control and status word
	localparam int HSIC_BIT_INS  = 0; // Insertion flag, write one to clear
	localparam int HSIC_BIT_EXT  = 1; // Extraction flag, write one to clear
	localparam int HSIC_BIT_LOO  = 2; // LED-on request
	localparam int HSIC_BIT_EIM  = 3; // ENUM mask
	// Field positions in miscellaneous control two
	localparam int HSIC_BIT_HOLD = 0; // Access hold
	// Event bits in the interrupt status and mask words
	localparam int HSIC_EV_INS   = 0; // Insertion flag was set
	localparam int HSIC_EV_EXT   = 1; // Extraction flag was set
	localparam int HSIC_EV_EJECT = 2; // Ejector latch changed
	localparam int HSIC_EV_W     = 3; // Number of events
	// Power-up option pin positions
	localparam int HSIC_OPT_EEPROM = 0; // EEPROM load enable
	localparam int HSIC_OPT_HOLD   = 1; // Access hold at power-up
	localparam int HSIC_OPT_MIN_W  = 2; // Fewest option pins the logic needs
	// Reset values
	localparam logic [3:0] HSIC_HS_RESET   = 4'h0;
	localparam logic [2:0] HSIC_MASK_RESET = 3'h0;
	// Sequencer states
	typedef enum logic [2:0]
	{
		HSIC_ST_RESET = 3'b000, // Internal reset active
		HSIC_ST_START = 3'b001, // First cycle out of reset
		HSIC_ST_LOAD  = 3'b010, // EEPROM load running
		HSIC_ST_HOLD  = 3'b011, // Access hold, config retried
		HSIC_ST_READY = 3'b100  // Enumerated, config accepted
	} hsic_state_t;
endpackage

// [hdl/hsic_sync.sv]
// Three-stage pin synchroniser that accepts a change once stages two and three agree
`timescale 1ns/10ps
`default_nettype none
module hsic_sync
	import hsic_pkg::*;
#(
	parameter int WIDTH = 1,
	parameter logic [WIDTH-1:0] INIT = '0
)
(
	input  wire logic             sys_clk_i,
	input  wire logic             rst_n_i,
	input  wire logic [WIDTH-1:0] pin_i,
	output logic      [WIDTH-1:0] level_o
);
	logic [WIDTH-1:0] meta_reg;  // First stage, read only by the second
	logic [WIDTH-1:0] mid_reg;   // Second stage
	logic [WIDTH-1:0] late_reg;  // Third stage
	logic [WIDTH-1:0] level_next;

	// Accept a new level only where the two settled stages agree
	always_comb
	begin
		level_next = level_o;
		for (int i = 0; i < WIDTH; i++)
		begin
			if (mid_reg[i] == late_reg[i])
			begin
				level_next[i] = mid_reg[i];
			end
		end
	end

	// Shift chain plus filtered output
	always_ff @(posedge sys_clk_i or negedge rst_n_i)
	begin
		if (!rst_n_i)
		begin
			meta_reg <= INIT;
			mid_reg  <= INIT;
			late_reg <= INIT;
			level_o  <= INIT;
		end
		else
		begin
			meta_reg <= pin_i;
			mid_reg  <= meta_reg;
			late_reg <= mid_reg;
			level_o  <= level_next;
		end
	end
endmodule
`default_nettype wire

// [verif/hsic_properties.sv]
// Port-level property checker for the hot-swap insertion control
`timescale 1ns/10ps
`default_nettype none
module hsic_checker
(
	input wire logic        sys_clk_i,
	input wire logic        rst_n_i,
	input wire logic        reg_rd_i,
	input wire logic [31:0] reg_rdata_o,
	input wire logic        slot_led_pin_o,
	input wire logic        slot_led_pin_oe_n_o,
	input wire logic        enum_n_o,
	input wire logic        enum_n_oe_n_o,
	input wire logic        local_reset_out_n_oe_n_o,
	input wire logic        outputs_float_o,
	input wire logic        eeprom_start_o,
	input wire logic        config_accept_o,
	input wire logic        config_retry_o
);
	// One clock domain, so clock and reset are given once
	default clocking cb @(posedge sys_clk_i); endclocking
	default disable iff (!rst_n_i);
	enum_pin_low_a: assert property (enum_n_o == 1'b0)
		else $error("enum pin value not low");
	led_pin_low_a: assert property (slot_led_pin_o == 1'b0)
		else $error("led pin value not low");
	led_lit_a: assert property ($rose(outputs_float_o) |-> ##[0:2] !slot_led_pin_oe_n_o)
		else $error("led not lit after back end went down");
	// outputs float in reset; two cycles allow for the register lag
	float_release_a: assert property (outputs_float_o && $past(outputs_float_o) |->
		enum_n_oe_n_o && local_reset_out_n_oe_n_o && !config_accept_o && !config_retry_o)
		else $error("output driven while back end down");
	accept_retry_a: assert property (!(config_accept_o && config_retry_o))
		else $error("accept and retry together");
	start_pulse_a: assert property (eeprom_start_o |=> !eeprom_start_o)
		else $error("load start longer than one cycle");
	enum_ready_a: assert property (!enum_n_oe_n_o |-> $past(config_accept_o))
		else $error("enum asserted outside ready");
	retry_enum_a: assert property (config_retry_o |=> enum_n_oe_n_o)
		else $error("enum asserted while retrying");
	// Read data only in the cycle after a read strobe
	rdata_idle_a: assert property (!$past(reg_rd_i) |-> reg_rdata_o == 32'h0000_0000)
		else $error("read data outside its cycle");
endmodule
bind hsic_top hsic_checker u_hsic_checker (.*);
`default_nettype wire

// [verif/hsic_eeprom_model.sv]
// Behavioural EEPROM loader that answers the start pulse after a set delay
`timescale 1ns/10ps
`default_nettype none
module hsic_eeprom_model
#(
	parameter int LAT = 6 // Load time in clocks, kept short for the run
)
(
	input  wire logic sys_clk_i,
	input  wire logic rst_n_i,
	input  wire logic start_i,
	output logic      done_o
);
	int cnt_reg; // Clocks left in the running load, zero when idle
	// Count down from a start, then flag done for one cycle
	always_ff @(posedge sys_clk_i or negedge rst_n_i)
	begin
		if (!rst_n_i)
		begin
			cnt_reg <= 0;
			done_o  <= 1'b0;
		end
		else
		begin
			done_o <= (cnt_reg == 1);
			if (start_i)
				cnt_reg <= LAT;
			else if (cnt_reg != 0)
				cnt_reg <= cnt_reg - 1;
		end
	end
endmodule
`default_nettype wire

// [verif/hsic_top_tb.sv]
// Self-checking bench for the hot-swap insertion control
`timescale 1ns/10ps
`default_nettype none
module hsic_top_tb
	import hsic_pkg::*;
;
	logic        sys_clk_i = 1'b0;
	logic        rst_n_i   = 1'b0;
	logic [7:0]  reg_addr_i = 8'h00;
	logic [31:0] reg_wdata_i = 32'h0000_0000;
	logic        reg_wr_i = 1'b0;
	logic        reg_rd_i = 1'b0;
	logic [31:0] reg_rdata_o;
	logic        healthy_n = 1'b1; // Back end down at power-up
	logic        ejector   = 1'b0; // Latch open
	logic        pci_rst_n = 1'b0;
	logic        lrst_in_n = 1'b1;
	logic [3:0]  opt       = 4'h1; // Load enabled, no hold
	logic        led, led_oe_n, enum_n, enum_oe_n, lro, lro_oe_n;
	logic        flt, start, done, acc, rty, irq;
	logic [31:0] rd_data;
	int          error_cnt = 0;
	int          checked   = 0;
	int          starts    = 0; // Load start pulses seen
	// Free-running system clock
	always #5 sys_clk_i = ~sys_clk_i;
	// Count load starts
	always @(posedge sys_clk_i)
		if (start === 1'b1)
			starts++;
	hsic_top u_hsic_top (.sys_clk_i(sys_clk_i), .rst_n_i(rst_n_i), .reg_addr_i(reg_addr_i),
		.reg_wdata_i(reg_wdata_i), .reg_wr_i(reg_wr_i), .reg_rd_i(reg_rd_i),
		.reg_rdata_o(reg_rdata_o), .backend_healthy_n_i(healthy_n),
		.ejector_switch_in_i(ejector), .pci_rst_n_i(pci_rst_n), .local_reset_in_n_i(lrst_in_n),
		.power_opt_i(opt), .slot_led_pin_o(led), .slot_led_pin_oe_n_o(led_oe_n),
		.enum_n_o(enum_n), .enum_n_oe_n_o(enum_oe_n), .local_reset_out_n_o(lro),
		.local_reset_out_n_oe_n_o(lro_oe_n), .outputs_float_o(flt), .eeprom_start_o(start),
		.eeprom_done_i(done), .config_accept_o(acc), .config_retry_o(rty), .irq_o(irq));
	hsic_eeprom_model u_hsic_eeprom_model (.sys_clk_i(sys_clk_i), .rst_n_i(rst_n_i),
		.start_i(start), .done_o(done));
	// Compare and count
	task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
		checked++;
		if (seen !== exp)
		begin
			error_cnt++;
			$display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
		end
	endtask
	// One-cycle register write
	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		@(posedge sys_clk_i);
		reg_wr_i    <= 1'b1;
		reg_addr_i  <= a;
		reg_wdata_i <= d;
		@(posedge sys_clk_i);
		reg_wr_i <= 1'b0;
	endtask
	// One-cycle register read, data taken in the following cycle
	task automatic rd(input logic [7:0] a);
		@(posedge sys_clk_i);
		reg_rd_i   <= 1'b1;
		reg_addr_i <= a;
		@(posedge sys_clk_i);
		reg_rd_i <= 1'b0;
		#1 rd_data = reg_rdata_o;
	endtask
	// Let cycles pass, then settle past the edge
	task automatic cyc(input int n);
		repeat (n) @(posedge sys_clk_i);
		#1;
	endtask
	// Bounded wait for configuration acceptance
	task automatic wait_acc();
		for (int i = 0; i < 60 && acc !== 1'b1; i++)
			cyc(1);
		cyc(2);
	endtask
	// Verdict and end of run
	task automatic results();
		if (error_cnt == 0 && checked > 0)
			$display("Test passed");
		else
			$display("Test failed");
		$finish;
	endtask
	// Watchdog well beyond the expected run of under a thousand clocks
	initial
	begin
		#100_000;
		error_cnt++;
		results();
	end
	initial
	begin
		repeat (10) @(posedge sys_clk_i);
		rst_n_i <= 1'b1;
		cyc(12);
		chk(led_oe_n, 1'b0);
		chk({enum_oe_n, lro_oe_n, flt, acc, rty}, 5'b11100);
		@(posedge sys_clk_i);
		healthy_n <= 1'b0;
		cyc(10);
		chk({lro_oe_n, lro, flt, acc}, 4'b0000);
		chk(led_oe_n, 1'b1);
		@(posedge sys_clk_i);
		pci_rst_n <= 1'b1;
		wait_acc();
		chk({acc, enum_oe_n, lro, starts[1:0]}, 5'b10101);
		rd(HSIC_ADDR_HS_STAT);
		chk(rd_data, 32'h0000_0001);
		rd(HSIC_ADDR_BLK_STAT);
		chk(rd_data[11:8], 4'h1);
		// Interrupt raised, read-cleared, unmapped read
		wr(HSIC_ADDR_IRQ_MASK, 32'h0000_0003);
		cyc(2);
		chk(irq, 1'b1);
		rd(HSIC_ADDR_IRQ_STAT);
		chk(rd_data[1:0], 2'b01);
		cyc(2);
		chk(irq, 1'b0);
		rd(8'h20);
		chk(rd_data, 32'h0000_0000);
		wr(HSIC_ADDR_HS_STAT, 32'h0000_0001);
		cyc(3);
		chk(enum_oe_n, 1'b1);
		rd(HSIC_ADDR_HS_STAT);
		chk(rd_data, 32'h0000_0000);
		wr(HSIC_ADDR_HS_STAT, 32'h0000_0004);
		cyc(2);
		chk(led_oe_n, 1'b0);
		wr(HSIC_ADDR_HS_STAT, 32'h0000_0000);
		cyc(2);
		chk(led_oe_n, 1'b1);
		@(posedge sys_clk_i);
		ejector <= 1'b1;
		cyc(10);
		rd(HSIC_ADDR_BLK_STAT);
		chk({rd_data[3], enum_oe_n}, 2'b11);
		@(posedge sys_clk_i);
		ejector <= 1'b0;
		cyc(10);
		chk({enum_oe_n, irq}, 2'b01);
		rd(HSIC_ADDR_HS_STAT);
		chk(rd_data, 32'h0000_0002);
		wr(HSIC_ADDR_HS_STAT, 32'h0000_0002);
		cyc(3);
		chk(enum_oe_n, 1'b1);
		wr(HSIC_ADDR_IRQ_MASK, 32'h0000_0000);
		cyc(2);
		chk(irq, 1'b0);
		rd(HSIC_ADDR_IRQ_STAT);
		wr(HSIC_ADDR_HS_STAT, 32'h0000_0008);
		@(posedge sys_clk_i);
		ejector <= 1'b1;
		cyc(8);
		@(posedge sys_clk_i);
		ejector <= 1'b0;
		cyc(10);
		chk(enum_oe_n, 1'b1);
		rd(HSIC_ADDR_HS_STAT);
		chk(rd_data, 32'h0000_000A);
		wr(HSIC_ADDR_HS_STAT, 32'h0000_000A);
		rd(HSIC_ADDR_HS_STAT);
		chk(rd_data, 32'h0000_0008);
		// back end cycled with access hold
		@(posedge sys_clk_i);
		opt <= 4'h2;
		cyc(4);
		@(posedge sys_clk_i);
		healthy_n <= 1'b1;
		cyc(10);
		chk({acc, flt, enum_oe_n, led_oe_n}, 4'b0110);
		@(posedge sys_clk_i);
		healthy_n <= 1'b0;
		cyc(12);
		chk({rty, acc, enum_oe_n, starts[1:0]}, 5'b10101);
		rd(HSIC_ADDR_MISC_TWO);
		chk(rd_data[0], 1'b1);
		wr(HSIC_ADDR_MISC_TWO, 32'h0000_0000);
		cyc(4);
		chk({rty, acc, enum_oe_n}, 3'b010);
		rd(HSIC_ADDR_HS_STAT);
		chk(rd_data, 32'h0000_0001);
		// PCI reset, local reset capture, late load
		@(posedge sys_clk_i);
		pci_rst_n <= 1'b0;
		opt       <= 4'h5;
		cyc(10);
		chk({acc, lro, lro_oe_n}, 3'b000);
		@(posedge sys_clk_i);
		lrst_in_n <= 1'b0;
		cyc(6);
		@(posedge sys_clk_i);
		lrst_in_n <= 1'b1;
		cyc(8);
		rd(HSIC_ADDR_BLK_STAT);
		chk(rd_data[11:8], 4'h5);
		@(posedge sys_clk_i);
		pci_rst_n <= 1'b1;
		wait_acc();
		chk({acc, starts[1:0]}, 3'b110);
		results();
	end
endmodule
`default_nettype wire
